// File: hw/comparator_params.svh
`ifndef COMPARATOR_PARAMS_SVH
`define COMPARATOR_PARAMS_SVH

`define CLK_PERIOD_NS 4
`define SET_COUNT 16
`define LEVEL_COUNT 4
`define JUDGE_COUNT 5
`define INPUT_COUNT 5
`define VALUE_W 32
`define LATCH_BIT 4
// chattering filter: least stable time after the input stage switches on
`define CHATTER_TIME_US 3000
`define CHATTER_CYCLES ((`CHATTER_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// lamp blink half period while difference entry is active
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYCLES ((`BLINK_HALF_MS * 1000000) / `CLK_PERIOD_NS)
`define DEB_CNT_W 20
`define BLINK_CNT_W 26
`define JUDGE_RESET 5'h01
`define PIN_IDLE 5'h1f

`endif

// File: hw/comparator_pkg.sv
package comparator_pkg;
  `include "comparator_params.svh"
  typedef logic signed [`VALUE_W-1:0] value_t;
  typedef enum logic [2:0] {
    OPERAND_CURRENT = 3'b000,
    OPERAND_MAX = 3'b001,
    OPERAND_MIN = 3'b010,
    OPERAND_PEAK = 3'b011,
    OPERAND_AXIS_SUM = 3'b100
  } operand_sel_e;
endpackage

// File: hw/multilevel_setpoint_comparator.sv
// Function
// - refuse setpoint not above earlier one
// - larger write clears all later setpoints
// - second setpoint only in manual mode
// - difference entry adds to previous, lamp blinks
// - sixteen sets, panel or external selection
// - five one-hot judgments, collector and relay
// - latch input freezes judgment outputs
// - operand: current, max, min, peak, axis sum
// - chattering filter needs 3ms stable input
// - value maps to output by setpoint band
// - set pins decoded active low binary
`timescale 1ns/1ns
`default_nettype none
module multilevel_setpoint_comparator
  import comparator_pkg::*;
#(
  parameter int DEB_CYCLES = `CHATTER_CYCLES,
  parameter int BLINK_CYCLES = `BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // measured operands
  input wire value_t meas_current,
  input wire value_t meas_max,
  input wire value_t meas_min,
  input wire value_t meas_peak,
  input wire value_t meas_axis_sum,
  input wire operand_sel_e operand_sel,
  // configuration
  input wire logic manual_mode,
  input wire logic chatter_en,
  input wire logic ext_select_en,
  input wire logic [3:0] panel_set,
  // setpoint entry
  input wire logic sp_wr_en,
  input wire logic sp_clear,
  input wire logic [3:0] sp_wr_set,
  input wire logic [1:0] sp_wr_index,
  input wire logic sp_diff_mode,
  input wire value_t sp_wr_value,
  // external pins, active low
  input wire logic set_select_bit0,
  input wire logic set_select_bit1,
  input wire logic set_select_bit2,
  input wire logic set_select_bit3,
  input wire logic latch_in_n,
  // outputs
  output logic [4:0] judgment_open_collector_out,
  output logic [4:0] judgment_relay_out,
  output logic reference_mode_lamp,
  output logic sp_wr_refused,
  output logic [3:0] active_set
);

  value_t sp_value_reg [`SET_COUNT][`LEVEL_COUNT];
  logic [`LEVEL_COUNT-1:0] sp_valid_reg [`SET_COUNT];
  logic [`INPUT_COUNT-1:0] sync1_reg, sync2_reg, filt_reg;
  logic [`DEB_CNT_W-1:0] deb_cnt_reg [`INPUT_COUNT];
  logic [`BLINK_CNT_W-1:0] blink_cnt_reg;
  logic [4:0] judge_oc_reg, judge_ry_reg;
  logic lamp_reg, refused_reg;
  logic [3:0] active_set_reg;

  // input pins cross into sys_clk through two flops
  wire [`INPUT_COUNT-1:0] pins = {latch_in_n, set_select_bit3, set_select_bit2,
                                  set_select_bit1, set_select_bit0};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= `PIN_IDLE;
      sync2_reg <= `PIN_IDLE;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // undriven pins float high, which reads as inactive
  localparam logic [`DEB_CNT_W-1:0] DEB_LAST = `DEB_CNT_W'(DEB_CYCLES - 1);
  genvar b;
  generate
    for (b = 0; b < `INPUT_COUNT; b++) begin : g_filter
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          filt_reg[b] <= 1'b1;
          deb_cnt_reg[b] <= '0;
        end else if (!chatter_en || sync2_reg[b] == filt_reg[b]) begin
          // without filtering the synchronised level passes straight on
          filt_reg[b] <= sync2_reg[b];
          deb_cnt_reg[b] <= '0;
        end else if (deb_cnt_reg[b] == DEB_LAST) begin
          filt_reg[b] <= sync2_reg[b];
          deb_cnt_reg[b] <= '0;
        end else begin
          deb_cnt_reg[b] <= deb_cnt_reg[b] + 1'b1;
        end
      end
    end
  endgenerate

  // set selection and latch
  wire [3:0] ext_set = ~filt_reg[3:0];
  wire [3:0] act_set = ext_select_en ? ext_set : panel_set;
  wire latch_active = ~filt_reg[`LATCH_BIT];

  // operand selection
  wire value_t operand = (operand_sel == OPERAND_MAX) ? meas_max :
                         (operand_sel == OPERAND_MIN) ? meas_min :
                         (operand_sel == OPERAND_PEAK) ? meas_peak :
                         (operand_sel == OPERAND_AXIS_SUM) ? meas_axis_sum : meas_current;

  // setpoints are held as a valid prefix in ascending order, so the count
  // of reached setpoints is the band number
  wire [`LEVEL_COUNT-1:0] reached;
  genvar k;
  generate
    for (k = 0; k < `LEVEL_COUNT; k++) begin : g_cmp
      assign reached[k] = sp_valid_reg[act_set][k] && (sp_value_reg[act_set][k] <= operand);
    end
  endgenerate
  wire [4:0] judge_next = {reached[3], reached[2] & ~reached[3],
                           reached[1] & ~reached[2], reached[0] & ~reached[1], ~reached[0]};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      judge_oc_reg <= `JUDGE_RESET;
      judge_ry_reg <= `JUDGE_RESET;
      active_set_reg <= '0;
    end else begin
      active_set_reg <= act_set;
      if (!latch_active) begin
        judge_oc_reg <= judge_next;
        judge_ry_reg <= judge_next;
      end
    end
  end

  // setpoint entry
  wire idx_nz = (sp_wr_index != 2'h0);
  wire [1:0] prev_idx = sp_wr_index - 2'h1;
  wire [1:0] next_idx = sp_wr_index + 2'h1;
  wire value_t prev_val = sp_value_reg[sp_wr_set][prev_idx];
  wire prev_ok = sp_valid_reg[sp_wr_set][prev_idx];
  wire value_t wr_val = sp_diff_mode ? value_t'(prev_val + sp_wr_value) : sp_wr_value;
  wire refuse = idx_nz ? (!manual_mode || !prev_ok || wr_val <= prev_val)
                       : sp_diff_mode;
  wire accept = sp_wr_en && !sp_clear && !refuse;
  // a later setpoint not above the new one breaks the order, so drop them all
  wire clear_later = (sp_wr_index != 2'h3) && sp_valid_reg[sp_wr_set][next_idx]
                     && (sp_value_reg[sp_wr_set][next_idx] <= wr_val);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < `SET_COUNT; s++) begin
        sp_valid_reg[s] <= '0;
        for (int l = 0; l < `LEVEL_COUNT; l++) begin
          sp_value_reg[s][l] <= '0;
        end
      end
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= sp_wr_en && !sp_clear && refuse;
      if (sp_clear) begin
        sp_valid_reg[sp_wr_set] <= '0;
      end else if (accept) begin
        sp_value_reg[sp_wr_set][sp_wr_index] <= wr_val;
        sp_valid_reg[sp_wr_set][sp_wr_index] <= 1'b1;
        for (int l = 0; l < `LEVEL_COUNT; l++) begin
          if (clear_later && l > sp_wr_index) begin
            sp_valid_reg[sp_wr_set][l] <= 1'b0;
          end
        end
      end
    end
  end

  // lamp blinks while difference entry is selected
  localparam logic [`BLINK_CNT_W-1:0] BLINK_LAST = `BLINK_CNT_W'(BLINK_CYCLES - 1);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blink_cnt_reg <= '0;
      lamp_reg <= 1'b0;
    end else if (!sp_diff_mode) begin
      blink_cnt_reg <= '0;
      lamp_reg <= 1'b0;
    end else if (blink_cnt_reg == BLINK_LAST) begin
      blink_cnt_reg <= '0;
      lamp_reg <= ~lamp_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end

  assign judgment_open_collector_out = judge_oc_reg;
  assign judgment_relay_out = judge_ry_reg;
  assign reference_mode_lamp = lamp_reg;
  assign sp_wr_refused = refused_reg;
  assign active_set = active_set_reg;

  // checks
  logic chk_clr_reg;
  logic [3:0] chk_set_reg;
  logic [1:0] chk_idx_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chk_clr_reg <= 1'b0;
      chk_set_reg <= '0;
      chk_idx_reg <= '0;
    end else begin
      chk_clr_reg <= accept && clear_later;
      chk_set_reg <= sp_wr_set;
      chk_idx_reg <= next_idx;
    end
  end

  property p_order_refused;
    @(posedge sys_clk) disable iff (rst)
      sp_wr_en && !sp_clear && idx_nz && prev_ok && wr_val <= prev_val |=> sp_wr_refused;
  endproperty
  a_order_refused: assert property (p_order_refused) else $error("non-ascending setpoint taken");

  property p_later_cleared;
    @(posedge sys_clk) disable iff (rst)
      chk_clr_reg |-> !sp_valid_reg[chk_set_reg][chk_idx_reg];
  endproperty
  a_later_cleared: assert property (p_later_cleared) else $error("later setpoint kept");

  property p_manual_only;
    @(posedge sys_clk) disable iff (rst)
      sp_wr_en && !sp_clear && idx_nz && !manual_mode |=> sp_wr_refused;
  endproperty
  a_manual_only: assert property (p_manual_only) else $error("second setpoint outside manual");

  property p_lamp_off;
    @(posedge sys_clk) disable iff (rst)
      !sp_diff_mode |=> !reference_mode_lamp;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit outside difference entry");

  property p_onehot;
    @(posedge sys_clk) disable iff (rst)
      $onehot(judgment_relay_out) && judgment_relay_out == judgment_open_collector_out;
  endproperty
  a_onehot: assert property (p_onehot) else $error("judgment not one-hot or pairs differ");

  property p_latch_hold;
    @(posedge sys_clk) disable iff (rst)
      latch_active |=> $stable(judgment_relay_out);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("judgment moved while latched");

  property p_filter_wait;
    @(posedge sys_clk) disable iff (rst)
      chatter_en && deb_cnt_reg[0] != DEB_LAST && sync2_reg[0] != filt_reg[0]
      |=> $stable(filt_reg[0]);
  endproperty
  a_filter_wait: assert property (p_filter_wait) else $error("input taken before stable time");

  property p_band_low;
    @(posedge sys_clk) disable iff (rst)
      !latch_active && !reached[0] |=> judgment_relay_out == 5'h01;
  endproperty
  a_band_low: assert property (p_band_low) else $error("below first setpoint not output 0");

  property p_band_top;
    @(posedge sys_clk) disable iff (rst)
      !latch_active && reached[3] |=> judgment_open_collector_out == 5'h10;
  endproperty
  a_band_top: assert property (p_band_top) else $error("top band not output 4");

  property p_set_decode;
    @(posedge sys_clk) disable iff (rst)
      ext_select_en |=> active_set == ~$past(filt_reg[3:0]);
  endproperty
  a_set_decode: assert property (p_set_decode) else $error("external set decoded wrong");

  c_latched: cover property (@(posedge sys_clk) disable iff (rst) $rose(latch_active));
  c_diff_accept: cover property (@(posedge sys_clk) disable iff (rst) accept && sp_diff_mode);
  c_top_band: cover property (@(posedge sys_clk) disable iff (rst) judgment_relay_out[4]);
  c_clear_later: cover property (@(posedge sys_clk) disable iff (rst) accept && clear_later);

endmodule
`default_nettype wire

// File: tb/set_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module set_pin_model #(
  parameter int MIN_GAP = 40
) (
  // clock
  input wire logic sys_clk,
  // commands from the bench
  input wire logic [3:0] req_set,
  input wire logic req_latch,
  input wire logic glitch,
  // pins, active low
  output logic [3:0] sel_n,
  output logic latch_n
);
  // start idle with the wait time already served, one writer per variable
  logic [3:0] held_set = 4'h0;
  logic held_latch = 1'b0;
  int gap = MIN_GAP;
  // a new change waits out the hold and wait time of the previous one
  always @(posedge sys_clk) begin
    if (gap < MIN_GAP) begin
      gap <= gap + 1;
    end else if (req_set !== held_set || req_latch !== held_latch) begin
      held_set <= req_set;
      held_latch <= req_latch;
      gap <= 0;
    end
  end
  // glitch only ever pulls bit 0 low, a deliberate short spike
  assign sel_n = glitch ? (~held_set & 4'he) : ~held_set;
  assign latch_n = ~held_latch;
endmodule
`default_nettype wire

// File: tb/multilevel_setpoint_comparator_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CMP(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module multilevel_setpoint_comparator_tb_top import comparator_pkg::*;;
  localparam int DEB = 8;
  localparam int BLINK = 4;
  localparam int GAP = 40;
  logic sys_clk, rst, manual, chat, ext_en, wr_en, clr, diff, latch_n, req_latch, glitch;
  logic [3:0] pset, wr_set, sel_n, req_set, aset;
  logic [1:0] wr_idx;
  value_t wr_val;
  value_t vals[5];
  operand_sel_e osel;
  logic [4:0] oc, ry;
  logic lamp, refused;
  int n_mismatch, cmp_count, cyc, seed, toggles;
  logic prev;
  logic [10:0] exp_q[$];
  logic [10:0] mask_q[$];
  logic [10:0] e, m;
  event smp;
  wire logic [10:0] obs;
  assign obs = {lamp, refused, aset, oc};

  multilevel_setpoint_comparator #(.DEB_CYCLES(DEB), .BLINK_CYCLES(BLINK)) dut (
    .sys_clk(sys_clk), .rst(rst), .meas_current(vals[0]), .meas_max(vals[1]),
    .meas_min(vals[2]), .meas_peak(vals[3]), .meas_axis_sum(vals[4]), .operand_sel(osel),
    .manual_mode(manual), .chatter_en(chat), .ext_select_en(ext_en), .panel_set(pset),
    .sp_wr_en(wr_en), .sp_clear(clr), .sp_wr_set(wr_set), .sp_wr_index(wr_idx),
    .sp_diff_mode(diff), .sp_wr_value(wr_val), .set_select_bit0(sel_n[0]),
    .set_select_bit1(sel_n[1]), .set_select_bit2(sel_n[2]), .set_select_bit3(sel_n[3]),
    .latch_in_n(latch_n), .judgment_open_collector_out(oc), .judgment_relay_out(ry),
    .reference_mode_lamp(lamp), .sp_wr_refused(refused), .active_set(aset));
  set_pin_model #(.MIN_GAP(GAP)) pins (.sys_clk(sys_clk), .req_set(req_set),
    .req_latch(req_latch), .glitch(glitch), .sel_n(sel_n), .latch_n(latch_n));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(logic [10:0] ev, logic [10:0] mv);
    exp_q.push_back(ev);
    mask_q.push_back(mv);
    -> smp;
  endtask

  task automatic wr(logic [3:0] s, logic [1:0] i, int v, logic d, logic r);
    wr_set = s;
    wr_idx = i;
    wr_val = v;
    diff = d;
    wr_en = 1'b1;
    step(1);
    wr_en = 1'b0;
    chk({1'b0, r, 9'h000}, 11'h200);
    // an idle edge keeps back to back writes from dropping and raising the strobe at once
    step(1);
  endtask

  task automatic band(int v, logic [4:0] j);
    vals[0] = v;
    step(2);
    chk({6'h00, j}, 11'h01f);
  endtask

  // every pending note is taken each time, so back to back notes never get lost
  always begin
    @(smp);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = mask_q.pop_front();
      `CMP("outputs", e & m, obs & m)
      `CMP("relay_copy", oc, ry)
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run;
    end
  end

  initial begin
    seed = 45800;
    {n_mismatch, cmp_count, cyc} = '0;
    {rst, manual, chat, ext_en, wr_en, clr, diff, req_latch, glitch} = 9'h140;
    {pset, wr_set, req_set, wr_idx} = '0;
    wr_val = '0;
    vals = '{default: '0};
    osel = OPERAND_CURRENT;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    step(1);
    chk(11'h001, 11'h7ff);
    band(50, 5'h01);
    wr(4'h0, 2'd0, 100, 1'b0, 1'b0);
    band(150, 5'h02);
    wr(4'h0, 2'd1, 200, 1'b0, 1'b1);
    manual = 1'b1;
    wr(4'h0, 2'd1, 200, 1'b0, 1'b0);
    wr(4'h0, 2'd2, 150, 1'b0, 1'b1);
    wr(4'h0, 2'd2, 200, 1'b0, 1'b1);
    wr(4'h0, 2'd2, 300, 1'b0, 1'b0);
    wr(4'h0, 2'd3, 400, 1'b0, 1'b0);
    band(450, 5'h10);
    wr(4'h0, 2'd1, 350, 1'b0, 1'b0);
    band(450, 5'h04);
    wr(4'h0, 2'd2, 10, 1'b1, 1'b0);
    band(360, 5'h08);
    band(359, 5'h04);
    toggles = 0;
    prev = lamp;
    repeat (2 * BLINK + 2) begin
      step(1);
      if (lamp !== prev) toggles++;
      prev = lamp;
    end
    `CMP("lamp_blink", 1'b1, toggles >= 2)
    wr(4'h2, 2'd0, 5, 1'b1, 1'b1);
    wr(4'h2, 2'd1, 5, 1'b0, 1'b1);
    diff = 1'b0;
    step(2);
    chk(11'h000, 11'h400);
    wr(4'h1, 2'd0, 0, 1'b0, 1'b0);
    pset = 4'h1;
    for (int k = 0; k < 5; k++) begin
      foreach (vals[j]) vals[j] = $random(seed);
      osel = operand_sel_e'(k);
      step(2);
      chk({6'h01, (vals[k] >= 0) ? 5'h02 : 5'h01}, 11'h7ff);
    end
    osel = OPERAND_CURRENT;
    wr_set = 4'h1;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    band(5, 5'h01);
    pset = 4'h0;
    ext_en = 1'b1;
    req_set = 4'h1;
    step(GAP + 5);
    chk(11'h020, 11'h1e0);
    req_set = 4'h0;
    step(GAP + 5);
    chk(11'h000, 11'h1e0);
    glitch = 1'b1;
    step(DEB - 2);
    chk(11'h000, 11'h1e0);
    glitch = 1'b0;
    step(DEB + 5);
    chk(11'h000, 11'h1e0);
    band(355, 5'h04);
    req_latch = 1'b1;
    step(GAP + 5);
    band(450, 5'h04);
    req_latch = 1'b0;
    step(GAP + 5);
    chk(11'h008, 11'h01f);
    step(2);
    complete_run;
  end
endmodule
`default_nettype wire
